/* rtl/cubp_cfg.svh */
// Purpose: constants of the current unbalance protection block
// Assumes: 25 MHz core clock
// Notes:   percent figures are whole percent
`ifndef CUBP_CFG_SVH
`define CUBP_CFG_SVH

`define CUBP_CUR_W        16
`define CUBP_PCT_W        7
`define CUBP_DLY_W        16
`define CUBP_PCT_MIN      7'h0A
`define CUBP_PCT_MAX      7'h5A
`define CUBP_PCT_DEF      7'h32
`define CUBP_DLY_MIN      16'h0064
`define CUBP_DLY_MAX      16'hEA60
`define CUBP_DLY_DEF      16'h03E8
`define CUBP_LOW_PCT      10
`define CUBP_HIGH_PCT     150
`define CUBP_HUNDRED      100
`define CUBP_CLK_HZ       25000000
`define CUBP_TICK_MS      1
`define CUBP_TICK_CYC     (`CUBP_CLK_HZ / 1000 * `CUBP_TICK_MS)

`endif

/* rtl/cubp_pkg.sv */
// Purpose: shared types of the current unbalance protection block
// Assumes: constants come from cubp_cfg.svh
// Notes:   none
`include "cubp_cfg.svh"
package cubp_pkg;
	typedef logic [`CUBP_CUR_W-1:0] cubp_cur_t;
	typedef logic [`CUBP_PCT_W-1:0] cubp_pct_t;
	typedef logic [`CUBP_DLY_W-1:0] cubp_dly_t;
	typedef enum logic [1:0]
	{
		CUBP_IDLE  = 2'b00,
		CUBP_TIMING = 2'b01,
		CUBP_TRIP  = 2'b10
	} cubp_state_t;
endpackage

/* rtl/cubp_unbalance_function.sv */
// Purpose: current unbalance decision, start and delayed trip
// Assumes: rms inputs and settings come from same-clock logic
// Notes:   settings outside their range are clamped to the range
//          TICK_CYC may shorten the millisecond tick for short runs
//
// Contract
// (RULE1) start when the max-minus-min phase gap exceeds the limit.
// (RULE2) start only while max current is above 10 % and below 150 % rated.
// (RULE3) the gap is taken as a percentage of the largest magnitude.
// (RULE4) operation off or the block input held high suppresses everything.
// (RULE5) trip only after the delay with start present and trip enabled.
// (RULE6) with start-only set the start shows but trip never asserts.
// (RULE7) start limit in percent, 10 to 90 in steps of one, default 50.
// (RULE8) trip delay in ms, 100 to 60000, default 1000, processing included.
// (RULE9) outside logic drives the block input that inhibits operation.
// (RULE10) upstream logic supplies the three fundamental rms magnitudes.
// (RULE11) delay is counted from the faulty state, not from the start output.
// (RULE12) two outputs, general start and general trip, with change pulses.
// (RULE13) counter clears when the condition drops and trip then falls.
`timescale 1ns/1ps
`include "cubp_cfg.svh"

module cubp_unbalance_function
#(
	parameter int TICK_CYC = `CUBP_TICK_CYC  // core cycles per millisecond
)
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire cubp_pkg::cubp_cur_t phaseACurrentRms,
	input  wire cubp_pkg::cubp_cur_t phaseBCurrentRms,
	input  wire cubp_pkg::cubp_cur_t phaseCCurrentRms,
	input  wire cubp_pkg::cubp_cur_t ratedCurrent,
	input  wire logic                operationOn,
	input  wire logic                startSignalOnly,
	input  wire cubp_pkg::cubp_pct_t startCurrentPct,
	input  wire cubp_pkg::cubp_dly_t timeDelayMs,
	input  wire logic                blockInput,
	output      logic                generalStartOut,
	output      logic                generalTripOut,
	output      logic                startEvent,
	output      logic                tripEvent
);
	import cubp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// analogue processing

	cubp_cur_t maxCur;
	cubp_cur_t minCur;
	cubp_pct_t limitPct;
	cubp_dly_t delayMs;
	logic      diffAbove;
	logic      maxCurrentSufficient;
	logic      maxCurrentNotFault;
	logic      faultCond;
	// product width: current width plus room for factors up to 150
	localparam int PW = `CUBP_CUR_W + 8;
	logic [PW-1:0] diffScaled;
	logic [PW-1:0] limScaled;
	logic [PW-1:0] maxScaled;
	logic [PW-1:0] lowScaled;
	logic [PW-1:0] highScaled;

	// pick largest and smallest phase magnitude
	always_comb
	begin
		maxCur = phaseACurrentRms;  // [RULE1]
		minCur = phaseACurrentRms;
		if (phaseBCurrentRms > maxCur) maxCur = phaseBCurrentRms;
		if (phaseCCurrentRms > maxCur) maxCur = phaseCCurrentRms;
		if (phaseBCurrentRms < minCur) minCur = phaseBCurrentRms;
		if (phaseCCurrentRms < minCur) minCur = phaseCCurrentRms;
	end

	// clamp settings into their legal ranges
	// a stray setting would otherwise silence or stretch the function
	always_comb
	begin
		limitPct = startCurrentPct;  // [RULE7]
		if (startCurrentPct < `CUBP_PCT_MIN) limitPct = `CUBP_PCT_MIN;
		if (startCurrentPct > `CUBP_PCT_MAX) limitPct = `CUBP_PCT_MAX;
		delayMs = timeDelayMs;  // [RULE8]
		if (timeDelayMs < `CUBP_DLY_MIN) delayMs = `CUBP_DLY_MIN;
		if (timeDelayMs > `CUBP_DLY_MAX) delayMs = `CUBP_DLY_MAX;
	end

	// percentage compares done by cross multiplication
	// no divider: both sides are scaled instead of dividing by the max
	// products stay below 2**24 for 16-bit currents and factors to 150
	always_comb
	begin
		diffScaled = PW'(maxCur - minCur) * PW'(`CUBP_HUNDRED);  // [RULE3]
		limScaled  = PW'(maxCur) * PW'(limitPct);
		maxScaled  = PW'(maxCur) * PW'(`CUBP_HUNDRED);
		lowScaled  = PW'(ratedCurrent) * PW'(`CUBP_LOW_PCT);
		highScaled = PW'(ratedCurrent) * PW'(`CUBP_HIGH_PCT);
		diffAbove  = diffScaled > limScaled;  // [RULE1]
		maxCurrentSufficient = maxScaled > lowScaled;  // [RULE2]
		maxCurrentNotFault   = maxScaled < highScaled;  // [RULE2]
		faultCond = operationOn && !blockInput && diffAbove
			&& maxCurrentSufficient && maxCurrentNotFault;  // [RULE4] [RULE9]
	end

	////////////////////////////////////////////////////////////////////////
	// millisecond tick

	localparam int TW = $clog2(TICK_CYC);
	logic [TW-1:0] tickCnt_q;
	logic [TW-1:0] tickCnt_d;
	logic          msTick;

	// tick restarts with each new faulty state so delay counts from it
	// a free-running tick would let the first millisecond come short
	always_comb
	begin
		msTick    = tickCnt_q == TW'(TICK_CYC - 1);
		tickCnt_d = (msTick || !faultCond) ? '0 : tickCnt_q + 1'b1;  // [RULE11]
	end

	always_ff @(posedge core_clk)
	begin
		if (rst) tickCnt_q <= '0;
		else     tickCnt_q <= tickCnt_d;
	end

	////////////////////////////////////////////////////////////////////////
	// decision logic

	cubp_state_t state_q;
	cubp_state_t state_d;
	cubp_dly_t   msCnt_q;
	cubp_dly_t   msCnt_d;
	logic        start_q;
	logic        start_d;
	logic        trip_q;
	logic        trip_d;
	logic        startEv_q;
	logic        startEv_d;
	logic        tripEv_q;
	logic        tripEv_d;

	// delay timer and trip decision
	// the counter sits at zero in idle so each fault gets a full delay
	always_comb
	begin
		state_d = state_q;
		msCnt_d = msCnt_q;
		unique case (state_q)
			CUBP_IDLE:
			begin
				msCnt_d = '0;
				if (faultCond) state_d = CUBP_TIMING;  // [RULE11]
			end
			CUBP_TIMING:
			begin
				if (!faultCond)
				begin
					state_d = CUBP_IDLE;  // [RULE13]
					msCnt_d = '0;
				end
				else if (msTick)
				begin
					msCnt_d = msCnt_q + 1'b1;
					if (msCnt_q + 1'b1 >= delayMs)
						state_d = CUBP_TRIP;  // [RULE5]
				end
			end
			CUBP_TRIP:
			begin
				if (!faultCond)
				begin
					state_d = CUBP_IDLE;  // [RULE13]
					msCnt_d = '0;
				end
			end
			// the unused code recovers to idle
			default:
			begin
				state_d = CUBP_IDLE;
				msCnt_d = '0;
			end
		endcase
		// trip needs the fault in the same cycle, so it falls right after it
		start_d   = faultCond;  // [RULE1]
		trip_d    = faultCond && (state_d == CUBP_TRIP)
			&& !startSignalOnly;  // [RULE5] [RULE6]
		// events compare each new level with the registered one
		startEv_d = start_d != start_q;  // [RULE12]
		tripEv_d  = trip_d != trip_q;  // [RULE12]
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q   <= CUBP_IDLE;
			msCnt_q   <= '0;
			start_q   <= 1'b0;
			trip_q    <= 1'b0;
			startEv_q <= 1'b0;
			tripEv_q  <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			msCnt_q   <= msCnt_d;
			start_q   <= start_d;
			trip_q    <= trip_d;
			startEv_q <= startEv_d;
			tripEv_q  <= tripEv_d;
		end
	end

	// registered outputs
	assign generalStartOut = start_q;  // [RULE12]
	assign generalTripOut  = trip_q;
	assign startEvent      = startEv_q;
	assign tripEvent       = tripEv_q;

endmodule // cubp_unbalance_function

/* testbench/cubp_unbalance_function_asserts.sv */
// Purpose: port checks of the unbalance block
// Assumes: bound to the top module
// Notes: the bench shortens the millisecond tick so trips occur
`timescale 1ns/1ps
module cubp_ub_chk
	import cubp_pkg::*;
(
	input	wire logic	core_clk,
	input	wire logic	rst,
	input	wire cubp_cur_t	phaseACurrentRms,
	input	wire cubp_cur_t	phaseBCurrentRms,
	input	wire cubp_cur_t	phaseCCurrentRms,
	input	wire cubp_cur_t	ratedCurrent,
	input	wire logic	operationOn,
	input	wire logic	startSignalOnly,
	input	wire cubp_pct_t	startCurrentPct,
	input	wire cubp_dly_t	timeDelayMs,
	input	wire logic	blockInput,
	input	wire logic	generalStartOut,
	input	wire logic	generalTripOut,
	input	wire logic	startEvent,
	input	wire logic	tripEvent
);
	logic [31:0] a, b, c, mx, mn, lim, r;
	logic flt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// fault condition from the phase magnitudes
	always_comb
	begin
		a = 32'(phaseACurrentRms);
		b = 32'(phaseBCurrentRms);
		c = 32'(phaseCCurrentRms);
		r = 32'(ratedCurrent);
		mx = a > b ? a : b;
		mx = mx > c ? mx : c;
		mn = a < b ? a : b;
		mn = mn < c ? mn : c;
		lim = 32'(startCurrentPct);
		lim = lim < 10 ? 10 : (lim > 90 ? 90 : lim);
		flt = operationOn && !blockInput && (mx - mn) * 100 > mx * lim
			&& mx * 100 > r * 10 && mx * 100 < r * 150;
	end
	start_on_a: assert property (flt |=> generalStartOut)
		else $error("start missing");
	start_off_a: assert property (!flt |=> !generalStartOut)
		else $error("start stray");
	block_quiet_a: assert property ((blockInput || !operationOn)
		|=> !generalStartOut && !generalTripOut) else $error("not quiet");
	start_only_a: assert property (startSignalOnly |=> !generalTripOut)
		else $error("trip in start only");
	trip_cause_a: assert property (generalTripOut |-> $past(flt))
		else $error("trip without fault");
	trip_falls_a: assert property (!flt |=> !generalTripOut)
		else $error("trip held");
	start_evt_a: assert property (startEvent == $changed(generalStartOut))
		else $error("start event");
	trip_evt_a: assert property (tripEvent == $changed(generalTripOut))
		else $error("trip event");
endmodule // cubp_ub_chk
bind cubp_unbalance_function cubp_ub_chk i_chk (.*);

/* testbench/cubp_meas_model.sv */
// Purpose: upstream rms stage model
// Assumes: one magnitude set per cycle
// Notes: phase b lowered by drop percent
`timescale 1ns/1ps
module cubp_meas_model
(
	input	wire logic	core_clk,
	input	wire logic [15:0]	base,
	input	wire logic [6:0]	drop,
	output	logic [15:0]	rmsA,
	output	logic [15:0]	rmsB,
	output	logic [15:0]	rmsC
);
	// registered magnitudes of the three phases
	always_ff @(posedge core_clk)
	begin
		rmsA <= base;
		rmsB <= 16'(32'(base) * (100 - 32'(drop)) / 100);
		rmsC <= base;
	end
endmodule // cubp_meas_model

/* testbench/cubp_unbalance_function_tb_top.sv */
// Purpose: boundary and random checks of the unbalance block
// Assumes: a four-cycle millisecond tick keeps trip delays short
// Notes: start changes are queued and matched on start pulses
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errCount++; \
	$display("unexpected %s exp %0h got %0h", n, e, a); end end
module cubp_unbalance_function_tb_top;
	import cubp_pkg::*;
	logic core_clk = 0, rst = 1, opOn = 0, sso = 0, blk = 0, lastExp = 0, nxt;
	localparam int TICK = 4; // short millisecond tick so trips fit the run
	logic expQ[$], tripQ[$];
	logic [15:0] base = 0, rated = 0, dly = 16'h03E8;
	logic [6:0] drop = 0, pct = 0;
	cubp_cur_t ra, rb, rc;
	logic st, tr, se, te;
	int errCount = 0, checked = 0;
	always #20 core_clk = ~core_clk;
	cubp_meas_model i_meas (.core_clk(core_clk), .base(base), .drop(drop),
		.rmsA(ra), .rmsB(rb), .rmsC(rc));
	cubp_unbalance_function #(.TICK_CYC(TICK)) i_dut (.core_clk(core_clk),
		.rst(rst),
		.phaseACurrentRms(ra), .phaseBCurrentRms(rb), .phaseCCurrentRms(rc),
		.ratedCurrent(rated), .operationOn(opOn), .startSignalOnly(sso),
		.startCurrentPct(pct), .timeDelayMs(dly), .blockInput(blk),
		.generalStartOut(st), .generalTripOut(tr), .startEvent(se),
		.tripEvent(te));
	// drive one setting, note a start change, hold four cycles
	task automatic apply(int b, int d, int r, int p, logic o, logic k, logic s);
		int lm;
		logic f;
		lm = p < 10 ? 10 : (p > 90 ? 90 : p);
		f = o && !k && (b - b * (100 - d) / 100) * 100 > b * lm
			&& b * 100 > r * 10 && b * 100 < r * 150;
		base <= 16'(b);
		drop <= 7'(d);
		// settings wait one edge so they meet the model's registered currents
		@(posedge core_clk);
		rated <= 16'(r);
		pct <= 7'(p);
		opOn <= o;
		blk <= k;
		sso <= s;
		if (f !== lastExp)
			expQ.push_back(f);
		lastExp = f;
		repeat (3) @(posedge core_clk);
	endtask
	// hold a fault, count edges from the drive until trip, then clear it
	task automatic trip_run(int d, logic s, int want);
		int cnt;
		dly <= 16'(d);
		if (!s)
			tripQ.push_back(1'b1);
		apply(1000, 60, 1000, 50, 1, 0, s);
		for (cnt = 4; cnt < want + 8 && tr !== 1'b1; cnt++)
		begin
			@(posedge core_clk);
			#1;
		end
		`CHK("delay", s ? want + 8 : want, cnt)
		@(posedge core_clk);
		if (!s)
			tripQ.push_back(1'b0);
		apply(1000, 0, 1000, 50, 1, 0, 0);
	endtask
	// compare each start change with the oldest note
	always @(negedge core_clk)
	begin
		if (se === 1'b1)
		begin
			nxt = expQ.size() ? expQ.pop_front() : ~st;
			`CHK("start", nxt, st)
		end
		if (te === 1'b1)
		begin
			nxt = tripQ.size() ? tripQ.pop_front() : ~tr;
			`CHK("trip", nxt, tr)
		end
	end
	// print counts and verdict, then stop
	task automatic results();
		$display("checks %0d errors %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// boundaries first, then random settings
	initial
	begin
		void'($urandom(11));
		repeat (6) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		apply(1000, 50, 1000, 50, 1, 0, 0);
		apply(1000, 51, 1000, 50, 1, 0, 0);
		apply(1000, 51, 1000, 50, 1, 1, 0);
		apply(100, 60, 1000, 50, 1, 0, 0);
		apply(101, 60, 1000, 50, 1, 0, 1);
		apply(1500, 60, 1000, 50, 1, 0, 0);
		apply(1499, 95, 1000, 127, 1, 0, 0);
		apply(1000, 60, 1000, 5, 0, 0, 0);
		// expected edges: one model register plus the delay in ticks
		trip_run(5, 0, 1 + 100 * TICK); // clamped up to 100 ms
		trip_run(150, 1, 1 + 150 * TICK);
		// a fault cut short must not shorten the next delay
		dly <= 16'h0078;
		apply(1000, 60, 1000, 50, 1, 0, 0);
		repeat (196) @(posedge core_clk);
		apply(1000, 0, 1000, 50, 1, 0, 0);
		trip_run(120, 0, 1 + 120 * TICK);
		for (int i = 0; i < 200; i++)
			apply($urandom_range(2000), $urandom_range(100),
				$urandom_range(1500, 500), $urandom_range(127),
				$urandom_range(3) != 0, $urandom_range(7) == 0, $urandom_range(1));
		for (int i = 0; i < 20 && expQ.size() + tripQ.size() > 0; i++)
			@(posedge core_clk);
		`CHK("queue", 0, expQ.size())
		`CHK("trip queue", 0, tripQ.size())
		`CHK("trip", 1'b0, tr)
		results();
	end
endmodule // cubp_unbalance_function_tb_top
